// ===== bench/lcdcd_decoder_props.sv
// Port-level properties of the LCD command decoder
`timescale 1ns/1ps
`default_nettype none
module lcdcd_decoder_props #(
  parameter int RESET_BUSY_CYCLES = 100
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic ramWriteValid,
  input wire logic ramWriteReady,
  input wire lcdcd_pkg::lcdcd_ram_wr_t ramWrite,
  input wire logic [7:0] statusByte,
  input wire logic busy,
  input wire logic rejectPulse,
  input wire logic displayOn,
  input wire logic segmentReverse,
  input wire logic [3:0] pageAddress,
  input wire logic [7:0] columnAddress,
  input wire logic [5:0] volumeLevel,
  input wire logic [2:0] resistorRatio
);
  import lcdcd_pkg::*;
  localparam int BUSY_MAX = RESET_BUSY_CYCLES + 4;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // Steps of one RAM write
  // ----------------------------------------
  sequence wrStart;
    $rose(ramWriteValid) && ramWrite.column < 8'h83;
  endsequence
  sequence wrStall;
    ramWriteValid && !ramWriteReady;
  endsequence
  // Display and busy flags compared only while steady; low bits always
  status_low_a: assert property (statusByte[3:0] == 4'h0)
    else $error("status low bits");
  status_disp_a: assert property ($stable(displayOn) |-> statusByte[5] == !displayOn)
    else $error("display flag");
  status_busy_a: assert property ($stable(busy) |-> statusByte[7:6] == {busy, !segmentReverse}
    && statusByte[4] == busy) else $error("busy flags");
  reset_dflt_a: assert property ($fell(srst) |-> busy && volumeLevel == 6'h20
    && resistorRatio == 3'h4 && pageAddress == 4'h0) else $error("reset defaults");
  busy_ends_a: assert property ($fell(srst) |-> ##[1:BUSY_MAX] !busy)
    else $error("busy stuck");
  page_range_a: assert property (pageAddress <= 4'h8)
    else $error("page range");
  reject_busy_a: assert property (rejectPulse |-> busy || $past(busy))
    else $error("idle reject");
  wr_hold_a: assert property (wrStall |=> ramWriteValid && $stable(ramWrite))
    else $error("write not held");
  col_adv_a: assert property (wrStart |-> columnAddress == ramWrite.column + 8'h01)
    else $error("column step");
  seg_map_a: assert property (wrStart |-> ramWrite.segment ==
    (segmentReverse ? 8'h83 - ramWrite.column : ramWrite.column)) else $error("segment map");
endmodule
bind lcdcd_decoder lcdcd_decoder_props #(.RESET_BUSY_CYCLES(RESET_BUSY_CYCLES)) props (.*);
`default_nettype wire

// ===== bench/lcdcd_decoder_tb.sv
// Self-checking bench of the LCD command decoder
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin numChecks++; if ((a) !== (e)) begin nErrors++; \
  $display("ERROR %s exp %0h got %0h", n, e, a); end end
module lcdcd_decoder_tb;
  import lcdcd_pkg::*;
  int nErrors = 0, numChecks = 0, seed = 70803, pg = 0, col = 0, segment_output = 0;
  logic sys_clk = 0, srst = 1, ramWriteReady = 0, stall = 0, seenRej = 0;
  logic serialClock, serialData, dataCommandSelect, leftChipSelect_n, rightChipSelect_n;
  logic ramWriteValid, busy, rejectPulse, rxOverflow, displayOn, powerSave, testMode;
  logic segmentReverse, commonReverse, readModifyWrite;
  logic [7:0] statusByte, columnAddress, v;
  logic [5:0] startLine, volumeLevel;
  logic [3:0] pageAddress;
  logic [2:0] powerControl, resistorRatio;
  logic [1:0] indicatorMode;
  lcdcd_ram_wr_t ramWrite, expW;
  lcdcd_ram_wr_t expQ[$];
  initial forever #5 sys_clk = ~sys_clk;
  lcdcd_decoder #(.RESET_BUSY_CYCLES(100)) DUT (.*, .entireOn(), .reverseDisplay(),
    .indicatorOn(), .biasSelect(), .partialDisplay());
  lcdcd_host_model host (.*);
  // Random RAM stalls; each taken write is checked
  always @(posedge sys_clk) begin
    if (!srst && !stall && ramWriteValid && ramWriteReady) begin
      expW = expQ.pop_front();
      `CHK("ramWrite", expW, ramWrite)
    end
    ramWriteReady <= !stall && ($random(seed) % 2 != 0);
    if (srst) seenRej <= 1'b0;
    else if (rejectPulse) seenRej <= 1'b1;
  end
  task automatic cmd(input logic [7:0] b);
    host.send(1'b0, b, 8);
    repeat (10) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [7:0] d);
    expQ.push_back({4'(pg), 8'(col), 8'(segment_output ? 131 - col : col), d});
    if (col < 131) col++;
    host.send(1'b1, d, 8);
  endtask
  // Bounded wait for writes and busy
  task automatic drain;
    for (int i = 0; i < 400 && (expQ.size() != 0 || busy !== 1'b0); i++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    `CHK("queue", 0, expQ.size())
  endtask
  task automatic endTest(input int t);
    $display("TB: test %0d done", t);
  endtask
  task automatic testDone;
    $display("TB: checks %0d errors %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #500000;
    nErrors++;
    testDone;
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    `CHK("status", 8'hF0, statusByte)
    `CHK("volume", 6'h20, volumeLevel)
    drain;
    `CHK("status", 8'h60, statusByte)
    endTest(1);
    cmd(8'hAF);
    `CHK("display", 1'b1, displayOn)
    `CHK("status", 8'h40, statusByte)
    cmd(8'hA5);
    cmd(8'hAE);
    `CHK("psave", 1'b1, powerSave)
    cmd(8'hAF);
    `CHK("psave", 1'b0, powerSave)
    cmd(8'hA4);
    for (int p = 0; p < 10; p++) begin
      cmd(8'hB0 | 8'(p));
      if (p < 9) pg = p;
      `CHK("page", 4'(pg), pageAddress)
    end
    for (int r = 0; r < 8; r++) begin
      v = 8'($random(seed));
      cmd(8'h20 | 8'(r));
      `CHK("ratio", 3'(r), resistorRatio)
      cmd(8'h28 | 8'(r));
      `CHK("power", 3'(r), powerControl)
      cmd({2'b01, v[5:0]});
      `CHK("start", v[5:0], startLine)
      cmd(8'h81);
      cmd(v);
      `CHK("volume", v[5:0], volumeLevel)
      cmd({4'hC, r[0], v[2:0]});
      `CHK("com", r[0], commonReverse)
      cmd(8'hAD);
      cmd(v);
      `CHK("indicator", v[1:0], indicatorMode)
    end
    cmd(8'hE3);
    cmd(8'hE8);
    `CHK("page kept", 4'h8, pageAddress)
    `CHK("volume kept", v[5:0], volumeLevel)
    cmd(8'hF5);
    `CHK("test", 1'b1, testMode)
    cmd(8'hF0);
    `CHK("test", 1'b0, testMode)
    endTest(2);
    cmd(8'hA1);
    segment_output = 1;
    `CHK("seg", 1'b1, segmentReverse)
    cmd(8'h18);
    cmd(8'h01);
    col = 129;
    `CHK("column", 8'h81, columnAddress)
    repeat (4) wr(8'($random(seed)));
    drain;
    `CHK("column", 8'h83, columnAddress)
    cmd(8'hA0);
    segment_output = 0;
    cmd(8'h10);
    cmd(8'h05);
    col = 5;
    cmd(8'hE0);
    `CHK("rmw", 1'b1, readModifyWrite)
    repeat (3) wr(8'($random(seed)));
    drain;
    cmd(8'hEE);
    col = 5;
    `CHK("rmw end", 8'h05, columnAddress)
    endTest(3);
    host.send(1'b0, 8'hB3, 4);
    cmd(8'hB2);
    `CHK("page", 4'h2, pageAddress)
    host.send(1'b0, 8'hE2, 8);
    host.send(1'b0, 8'hB5, 8);
    #100;
    `CHK("rejected", 1'b1, seenRej)
    `CHK("status", 8'hD0, statusByte)
    drain;
    `CHK("page", 4'h0, pageAddress)
    `CHK("column", 8'h00, columnAddress)
    `CHK("volume", 6'h20, volumeLevel)
    `CHK("display", 1'b1, displayOn)
    endTest(4);
    @(posedge sys_clk) stall <= 1'b1;
    repeat (20) host.send(1'b1, 8'h5A, 8);
    repeat (8) @(posedge sys_clk);
    `CHK("overflow", 1'b1, rxOverflow)
    @(posedge sys_clk) srst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    {srst, stall} <= 2'b00;
    drain;
    `CHK("overflow", 1'b0, rxOverflow)
    `CHK("display", 1'b0, displayOn)
    endTest(5);
    testDone;
  end
endmodule
`default_nettype wire

// ===== bench/lcdcd_host_model.sv
// Host microcontroller model driving the write-only serial link
`timescale 1ns/1ps
`default_nettype none
module lcdcd_host_model (
  output logic serialClock,
  output logic serialData,
  output logic dataCommandSelect,
  output logic leftChipSelect_n,
  output logic rightChipSelect_n
);
  logic useRight = 1'b0;
  // Link idles deselected with its clock standing high
  initial {serialClock, serialData, dataCommandSelect, rightChipSelect_n, leftChipSelect_n} = 5'h13;
  // n bits MSB first; n below 8 tears the byte
  task automatic send(input logic a0, input logic [7:0] b, input int n);
    useRight = ~useRight;
    {rightChipSelect_n, leftChipSelect_n} = useRight ? 2'b01 : 2'b10;
    dataCommandSelect = a0;
    for (int i = 7; i > 7 - n; i--) begin
      #40 serialClock = 1'b0;
      serialData = b[i];
      #40 serialClock = 1'b1;
    end
    #40 {rightChipSelect_n, leftChipSelect_n} = 2'b11;
    serialData = ~serialData; // Released line shows no stale level
    dataCommandSelect = ~a0;
    #80;
  endtask
endmodule
`default_nettype wire

// ===== verilog/lcdcd_decoder.sv
// LCD controller command decoder: serial bytes to settings and RAM writes
//
// Notes on behaviour
// R1: With chip selected, bits shift in MSB first; eighth rising edge forms a byte.
// R2: Display on/off command: lowest bit one turns panel on, zero off.
// R3: Display off while all points forced on enters power save.
// R4: Command 01xxxxxx loads six-bit display start line.
// R5: Page command loads four-bit page; pages 0 to 8 are valid.
// R6: Two commands give upper and lower column nibbles; column 0 to 131.
// R7: Column increments per RAM access up to 131; page never changes.
// R8: Status byte: busy, segment direction, display state, reset progress, low zeros.
// R9: Every command is rejected while busy.
// R10: Display-state status bit is the inverse of display on.
// R11: Reset-progress bit is high while pin or command reset runs.
// R12: Data byte writes RAM at page and column, then column advances.
// R13: Nothing can be read back over the serial link.
// R14: Segment-direction command lowest bit: zero normal, one reversed.
// R15: Reversed segments take column 131 minus n; normal takes column n.
// R16: Read-modify-write counts on writes; end restores saved column.
// R17: Software reset restores address and mode registers, keeps RAM.
// R18: Common mode command uses bit three as scan direction, ignores low bits.
// R19: Six-bit volume, default 32, loaded by byte after volume mode command.
// R20: Three-bit resistor ratio set by its own command.
// R21: Two-bit indicator mode loaded by byte after indicator-on command.
// R22: Host avoids test codes; test-mode reset command leaves test mode.
// R23: No-operation changes nothing.
// R24: After volume mode command only the volume byte is taken, then mode ends.
// R25: With chip deselected shift register and bit counter stay cleared.
// R26: Undefined codes change nothing.
// R27: Pin reset clears all registers, counters and pending states, except ratio and volume, which load defaults, and the busy count and flag, which load.
`timescale 1ns/1ps
`default_nettype none
`include "lcdcd_map.svh"
module lcdcd_decoder #(
  parameter int RESET_BUSY_CYCLES = `LCDCD_RESET_BUSY_CYC,
  parameter int FIFO_DEPTH = `LCDCD_FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic dataCommandSelect,
  input wire logic leftChipSelect_n,
  input wire logic rightChipSelect_n,
  input wire logic ramWriteReady,
  output logic ramWriteValid,
  output lcdcd_pkg::lcdcd_ram_wr_t ramWrite,
  output logic [7:0] statusByte,
  output logic busy,
  output logic rejectPulse,
  output logic rxOverflow,
  output logic displayOn,
  output logic entireOn,
  output logic powerSave,
  output logic reverseDisplay,
  output logic segmentReverse,
  output logic commonReverse,
  output logic [5:0] startLine,
  output logic [3:0] pageAddress,
  output logic [7:0] columnAddress,
  output logic readModifyWrite,
  output logic [2:0] powerControl,
  output logic [2:0] resistorRatio,
  output logic [5:0] volumeLevel,
  output logic indicatorOn,
  output logic [1:0] indicatorMode,
  output logic biasSelect,
  output logic partialDisplay,
  output logic testMode
);
  import lcdcd_pkg::*;

  localparam int BW = $clog2(RESET_BUSY_CYCLES + 1);

  typedef struct packed {
    logic [BW-1:0] resetCount;
    logic busy;
    lcdcd_pend_t pending;

    logic displayOn;
    logic entireOn;
    logic powerSave;
    logic reverseDisplay;
    logic segmentReverse;
    logic commonReverse;
    logic [5:0] startLine;
    logic [3:0] page;
    logic [7:0] column;
    logic [7:0] savedColumn;
    logic readModifyWrite;
    logic [2:0] powerControl;
    logic [2:0] resistorRatio;
    logic [5:0] volume;
    logic indicatorOn;
    logic [1:0] indicatorMode;
    logic biasSelect;
    logic partialDisplay;
    logic testMode;

    logic wrValid;
    lcdcd_ram_wr_t wr;
    logic reject;
    logic overflow;
  } lcdcd_st_t;

  lcdcd_st_t st_r;
  lcdcd_st_t st_nxt;
  lcdcd_byte_t rxByte;
  lcdcd_byte_t head;
  logic rxValid;
  logic rxReady;
  logic rxOvf;
  logic headValid;
  logic pop;
  logic inReset;
  logic chipActive_n;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Compare the fixed bits of a command code
  function automatic logic cmdMatch(input logic [7:0] b, input logic [7:0] code,
                                    input logic [7:0] mask);
    cmdMatch = ((b & mask) == (code & mask));
  endfunction

  // Column after one access: counts up and holds at the last column
  function automatic logic [7:0] colStep(input logic [7:0] col);
    colStep = (col >= `LCDCD_LAST_COL) ? `LCDCD_LAST_COL : col + 8'h01; // R7
  endfunction

  // Segment that shows a column under the chosen direction
  function automatic logic [7:0] segOf(input logic [7:0] col, input logic rev);
    segOf = rev ? (`LCDCD_LAST_COL - col) : col; // R15
  endfunction

  // ----------------------------------------------------------------
  // Serial front end and byte buffer
  // ----------------------------------------------------------------

  // Either half's select opens the link
  assign chipActive_n = leftChipSelect_n && rightChipSelect_n;

  lcdcd_serial_rx u_rx (
    .sys_clk(sys_clk),
    .srst(srst),
    .serialClock(serialClock),
    .serialData(serialData),
    .dataCommandSelect(dataCommandSelect),
    .chipActive_n(chipActive_n),
    .rxByte(rxByte),
    .rxValid(rxValid),
    .rxReady(rxReady),
    .rxOverflow(rxOvf)
  );

  lcdcd_fifo #(
    .WIDTH($bits(lcdcd_byte_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .inValid(rxValid),
    .inReady(rxReady),
    .inData(rxByte),
    .outValid(headValid),
    .outReady(pop),
    .outData(head)
  );

  // ----------------------------------------------------------------
  // Drain: a pending RAM write that the RAM has not taken stalls
  // the buffer, so a slow RAM port backs the stream up into the FIFO
  // ----------------------------------------------------------------
  assign inReset = st_r.busy; // R11
  assign pop = headValid && (!st_r.wrValid || ramWriteReady);

  // ----------------------------------------------------------------
  // Decoder
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.reject = 1'b0;
    st_nxt.overflow = rxOvf;

    // Write taken by the RAM
    if (st_r.wrValid && ramWriteReady) begin
      st_nxt.wrValid = 1'b0;
    end

    if (inReset) begin
      st_nxt.resetCount = st_r.resetCount - 1'b1; // R11
    end

    if (pop && inReset) begin
      // Busy: the byte is consumed and thrown away
      st_nxt.reject = 1'b1; // R9
    end else if (pop && st_r.pending == PEND_VOLUME) begin
      // Whatever byte follows is taken as the volume value
      st_nxt.volume = head.data[5:0]; // R19 R24
      st_nxt.pending = PEND_NONE; // R24
    end else if (pop && st_r.pending == PEND_INDICATOR) begin
      st_nxt.indicatorMode = head.data[1:0]; // R21
      st_nxt.pending = PEND_NONE;
    end else if (pop && head.dataCommandSelect) begin
      // Display data write at the current page and column
      st_nxt.wrValid = 1'b1; // R12
      st_nxt.wr.page = st_r.page;
      st_nxt.wr.column = st_r.column;
      st_nxt.wr.segment = segOf(st_r.column, st_r.segmentReverse); // R15
      st_nxt.wr.data = head.data; // R12
      st_nxt.column = colStep(st_r.column); // R7 R12 R16
    end else if (pop) begin
      if (cmdMatch(head.data, `LCDCD_CMD_DISP, `LCDCD_MASK_D0)) begin
        st_nxt.displayOn = head.data[0]; // R2
        if (!head.data[0] && st_r.entireOn) begin
          st_nxt.powerSave = 1'b1; // R3
        end else if (head.data[0]) begin
          st_nxt.powerSave = 1'b0;
        end
      end else if (cmdMatch(head.data, `LCDCD_CMD_START, `LCDCD_MASK_LO6)) begin
        st_nxt.startLine = head.data[5:0]; // R4
      end else if (cmdMatch(head.data, `LCDCD_CMD_PAGE, `LCDCD_MASK_LO4)) begin
        // Pages beyond the single-line page do not exist
        if (head.data[3:0] <= `LCDCD_LAST_PAGE) begin
          st_nxt.page = head.data[3:0]; // R5
        end
      end else if (cmdMatch(head.data, `LCDCD_CMD_COLHI, `LCDCD_MASK_LO4)) begin
        st_nxt.column = {head.data[3:0], st_r.column[3:0]}; // R6
      end else if (cmdMatch(head.data, `LCDCD_CMD_COLLO, `LCDCD_MASK_LO4)) begin
        st_nxt.column = {st_r.column[7:4], head.data[3:0]}; // R6
      end else if (cmdMatch(head.data, `LCDCD_CMD_ADC, `LCDCD_MASK_D0)) begin
        st_nxt.segmentReverse = head.data[0]; // R14
      end else if (cmdMatch(head.data, `LCDCD_CMD_REV, `LCDCD_MASK_D0)) begin
        st_nxt.reverseDisplay = head.data[0];
      end else if (cmdMatch(head.data, `LCDCD_CMD_ALLON, `LCDCD_MASK_D0)) begin
        st_nxt.entireOn = head.data[0];
        // All points on while the display is off is the other way in
        st_nxt.powerSave = head.data[0] && !st_r.displayOn;
      end else if (cmdMatch(head.data, `LCDCD_CMD_BIAS, `LCDCD_MASK_D0)) begin
        st_nxt.biasSelect = head.data[0];
      end else if (cmdMatch(head.data, `LCDCD_CMD_RMW, `LCDCD_MASK_ALL)) begin
        st_nxt.readModifyWrite = 1'b1; // R16
        st_nxt.savedColumn = st_r.column; // R16
      end else if (cmdMatch(head.data, `LCDCD_CMD_END, `LCDCD_MASK_ALL)) begin
        // Without a prior read-modify-write there is nothing to restore
        if (st_r.readModifyWrite) begin
          st_nxt.column = st_r.savedColumn; // R16
        end
        st_nxt.readModifyWrite = 1'b0; // R16
      end else if (cmdMatch(head.data, `LCDCD_CMD_RESET, `LCDCD_MASK_ALL)) begin
        // Display RAM and power control are left alone
        st_nxt.startLine = '0; // R17
        st_nxt.column = '0; // R17
        st_nxt.page = '0; // R17
        st_nxt.commonReverse = 1'b0; // R17
        st_nxt.resistorRatio = `LCDCD_RATIO_DEF; // R17
        st_nxt.volume = `LCDCD_VOLUME_DEF; // R17
        st_nxt.indicatorOn = 1'b0; // R17
        st_nxt.indicatorMode = '0; // R17
        st_nxt.readModifyWrite = 1'b0; // R17
        st_nxt.testMode = 1'b0; // R17
        st_nxt.resetCount = BW'(RESET_BUSY_CYCLES); // R11
      end else if (cmdMatch(head.data, `LCDCD_CMD_NOP, `LCDCD_MASK_ALL)) begin
        st_nxt.reject = 1'b0; // R23
      end else if (cmdMatch(head.data, `LCDCD_CMD_COM, `LCDCD_MASK_LO4)) begin
        st_nxt.commonReverse = head.data[3]; // R18
      end else if (cmdMatch(head.data, `LCDCD_CMD_POWER, `LCDCD_MASK_LO3)) begin
        st_nxt.powerControl = head.data[2:0];
      end else if (cmdMatch(head.data, `LCDCD_CMD_RATIO, `LCDCD_MASK_LO3)) begin
        st_nxt.resistorRatio = head.data[2:0]; // R20
      end else if (cmdMatch(head.data, `LCDCD_CMD_VOLSET, `LCDCD_MASK_ALL)) begin
        st_nxt.pending = PEND_VOLUME; // R19 R24
      end else if (cmdMatch(head.data, `LCDCD_CMD_IND, `LCDCD_MASK_D0)) begin
        st_nxt.indicatorOn = head.data[0];
        st_nxt.pending = head.data[0] ? PEND_INDICATOR : PEND_NONE; // R21
      end else if (cmdMatch(head.data, `LCDCD_CMD_PARTIAL, `LCDCD_MASK_D0)) begin
        st_nxt.partialDisplay = head.data[0];
      end else if (cmdMatch(head.data, `LCDCD_CMD_TESTRST, `LCDCD_MASK_ALL)) begin
        st_nxt.testMode = 1'b0; // R22
      end else if (cmdMatch(head.data, `LCDCD_CMD_TEST, `LCDCD_MASK_LO4)) begin
        // Factory test codes only raise a flag; nothing else obeys them
        st_nxt.testMode = 1'b1; // R22
      end else begin
        st_nxt.reject = 1'b0; // R26
      end
    end

    // Busy from a flop
    st_nxt.busy = (st_nxt.resetCount != '0); // R9 R11
  end

  // ----------------------------------------------------------------
  // State register: pin reset loads every default and starts the
  // reset-in-progress interval
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0; // R27
      st_r.pending <= PEND_NONE; // R27
      st_r.resistorRatio <= `LCDCD_RATIO_DEF; // R27
      st_r.volume <= `LCDCD_VOLUME_DEF; // R27
      st_r.resetCount <= BW'(RESET_BUSY_CYCLES); // R11 R27
      st_r.busy <= 1'b1; // R11 R27
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all taken straight from the state register
  // ----------------------------------------------------------------
  assign statusByte = {inReset, !st_r.segmentReverse, !st_r.displayOn, inReset, 4'h0}; // R8 R10
  assign busy = inReset; // R9 R11

  assign rejectPulse = st_r.reject;
  assign rxOverflow = st_r.overflow;

  assign ramWriteValid = st_r.wrValid;
  assign ramWrite = st_r.wr;

  assign displayOn = st_r.displayOn;
  assign entireOn = st_r.entireOn;
  assign powerSave = st_r.powerSave;
  assign reverseDisplay = st_r.reverseDisplay;
  assign segmentReverse = st_r.segmentReverse;
  assign commonReverse = st_r.commonReverse;
  assign startLine = st_r.startLine;
  assign pageAddress = st_r.page;
  assign columnAddress = st_r.column;
  assign readModifyWrite = st_r.readModifyWrite;
  assign powerControl = st_r.powerControl;
  assign resistorRatio = st_r.resistorRatio;
  assign volumeLevel = st_r.volume;
  assign indicatorOn = st_r.indicatorOn;
  assign indicatorMode = st_r.indicatorMode;
  assign biasSelect = st_r.biasSelect;
  assign partialDisplay = st_r.partialDisplay;
  assign testMode = st_r.testMode;
endmodule
`default_nettype wire

// ===== verilog/lcdcd_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module lcdcd_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } lcdcd_fifo_st_t;

  lcdcd_fifo_st_t st_r;
  lcdcd_fifo_st_t st_nxt;
  logic full;
  logic empty;

  // ----------------------------------------------------------------
  // Flags: pointers differ only in the wrap bit when full
  // ----------------------------------------------------------------
  assign empty = (st_r.wrPtr == st_r.rdPtr);
  assign full = (st_r.wrPtr[AW-1:0] == st_r.rdPtr[AW-1:0]) && (st_r.wrPtr[AW] != st_r.rdPtr[AW]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = st_r.mem[st_r.rdPtr[AW-1:0]];

  // Next state
  always_comb begin
    st_nxt = st_r;
    if (inValid && !full) begin
      st_nxt.mem[st_r.wrPtr[AW-1:0]] = inData;
      st_nxt.wrPtr = st_r.wrPtr + 1'b1;
    end
    if (outReady && !empty) begin
      st_nxt.rdPtr = st_r.rdPtr + 1'b1;
    end
  end

  // Register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/lcdcd_map.svh
// Constants of the LCD command decoder: codes, masks, defaults and timing
`ifndef LCDCD_MAP_SVH
`define LCDCD_MAP_SVH

// ----------------------------------------------------------------
// Serial framing
// ----------------------------------------------------------------
`define LCDCD_BITS_PER_BYTE 3'h7
`define LCDCD_FIFO_DEPTH 16

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LCDCD_CLK_MHZ 100
`define LCDCD_RESET_BUSY_NS 1000
`define LCDCD_RESET_BUSY_CYC ((`LCDCD_RESET_BUSY_NS * `LCDCD_CLK_MHZ) / 1000)

// ----------------------------------------------------------------
// Command codes and the masks of their fixed bits
// ----------------------------------------------------------------
`define LCDCD_MASK_ALL 8'hFF
`define LCDCD_MASK_D0 8'hFE
`define LCDCD_MASK_LO3 8'hF8
`define LCDCD_MASK_LO4 8'hF0
`define LCDCD_MASK_LO6 8'hC0
`define LCDCD_CMD_DISP 8'hAE
`define LCDCD_CMD_START 8'h40
`define LCDCD_CMD_PAGE 8'hB0
`define LCDCD_CMD_COLHI 8'h10
`define LCDCD_CMD_COLLO 8'h00
`define LCDCD_CMD_ADC 8'hA0
`define LCDCD_CMD_REV 8'hA6
`define LCDCD_CMD_ALLON 8'hA4
`define LCDCD_CMD_BIAS 8'hA2
`define LCDCD_CMD_RMW 8'hE0
`define LCDCD_CMD_END 8'hEE
`define LCDCD_CMD_RESET 8'hE2
`define LCDCD_CMD_NOP 8'hE3
`define LCDCD_CMD_COM 8'hC0
`define LCDCD_CMD_POWER 8'h28
`define LCDCD_CMD_RATIO 8'h20
`define LCDCD_CMD_VOLSET 8'h81
`define LCDCD_CMD_IND 8'hAC
`define LCDCD_CMD_PARTIAL 8'h82
`define LCDCD_CMD_TESTRST 8'hF0
`define LCDCD_CMD_TEST 8'hF0

// ----------------------------------------------------------------
// Limits and reset values
// ----------------------------------------------------------------
`define LCDCD_LAST_PAGE 4'h8
`define LCDCD_LAST_COL 8'h83
`define LCDCD_RATIO_DEF 3'h4
`define LCDCD_VOLUME_DEF 6'h20

`endif

// ===== verilog/lcdcd_pkg.sv
// Types shared by the LCD command decoder modules
package lcdcd_pkg;

  // Received byte with its data/command select
  typedef struct packed {
    logic dataCommandSelect;
    logic [7:0] data;
  } lcdcd_byte_t;

  // Second byte expected by a double-byte command
  typedef enum logic [1:0] {
    PEND_NONE,
    PEND_VOLUME,
    PEND_INDICATOR
  } lcdcd_pend_t;

  // One write into display RAM
  typedef struct packed {
    logic [3:0] page;
    logic [7:0] column;
    logic [7:0] segment;
    logic [7:0] data;
  } lcdcd_ram_wr_t;

endpackage

// ===== verilog/lcdcd_serial_rx.sv
// Serial byte receiver: samples the link pins and assembles bytes
`timescale 1ns/1ps
`default_nettype none
module lcdcd_serial_rx
  import lcdcd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic dataCommandSelect,
  input wire logic chipActive_n,
  output lcdcd_pkg::lcdcd_byte_t rxByte,
  output logic rxValid,
  input wire logic rxReady,
  output logic rxOverflow
);
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic sclPrev;
    logic [6:0] shift;
    logic [2:0] count;
    lcdcd_byte_t outByte;
    logic outValid;
    logic overflow;
  } lcdcd_rx_st_t;

  lcdcd_rx_st_t st_r;
  lcdcd_rx_st_t st_nxt;
  logic scl;
  logic si;
  logic dcs;
  logic csOn;

  // Synchronised pin levels, read only from the second stage
  assign scl = st_r.sync2[3];
  assign si = st_r.sync2[2];
  assign dcs = st_r.sync2[1];
  assign csOn = !st_r.sync2[0];
  assign rxByte = st_r.outByte;
  assign rxValid = st_r.outValid;
  assign rxOverflow = st_r.overflow;

  // ----------------------------------------------------------------
  // Shifter
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = {serialClock, serialData, dataCommandSelect, chipActive_n};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sclPrev = scl;
    st_nxt.outValid = 1'b0;
    if (!csOn) begin
      st_nxt.shift = '0; // R25
      st_nxt.count = '0; // R25
    end else if (scl && !st_r.sclPrev) begin
      // Most significant bit arrives first
      st_nxt.shift = {st_r.shift[5:0], si}; // R1
      st_nxt.count = st_r.count + 1'b1;
      if (st_r.count == `LCDCD_BITS_PER_BYTE) begin
        // A full FIFO drops the byte and leaves a sticky flag
        st_nxt.outByte = '{dataCommandSelect: dcs, data: {st_r.shift, si}}; // R1
        st_nxt.outValid = rxReady;
        st_nxt.overflow = st_r.overflow || !rxReady;
      end
    end
  end

  // Register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.sync1 <= 4'hF;
      st_r.sync2 <= 4'hF;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire
